// ==== rtl/pso_pkg.sv ====
// Constants for the supply on/off, protection latch and status lamp logic.
// Assumes a 100 MHz system clock and a synchronous active-high reset.
package pso_pkg;
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned OV_LATCH_US    = 1000;   // Longest over-voltage latch time
   localparam int unsigned SC_REG_US      = 2000;   // Short-circuit regulation time
   localparam int unsigned SC_LATCH_MS    = 500;    // Short-circuit latch-off time
   localparam int unsigned BLINK_HZ       = 1;
   localparam int unsigned OV_CYC    = OV_LATCH_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SC_REG_CYC  = SC_REG_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SC_LATCH_CYC = SC_LATCH_MS * (CLK_HZ / 1000);
   localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
   localparam int unsigned CNT_W = 32;
   // AXI4-Lite register map
   localparam logic [3:0] CTRL_OFS   = 4'h0;   // Bit0 restart, bit1 bus on-request
   localparam logic [3:0] STATUS_OFS = 4'h4;   // Live state and latches
   localparam int unsigned CTRL_RESTART_BIT = 0;
   localparam int unsigned CTRL_BUSON_BIT   = 1;
   localparam logic        CTRL_BUSON_RST   = 1'b1;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {LAMP_OFF = 2'h0, LAMP_ON = 2'h1, LAMP_BLINK = 2'h3} pso_lamp_type;
endpackage

// ==== rtl/pso_onoff.sv ====
// Supply on/off control, protection latches, lamps and alert, with an AXI4-Lite slave.
// Assumes detector inputs come from comparators outside the clock domain.
// Contract
// [RQ1] Main output on only when force-off and on-request are both low.
// [RQ2] Floating force-off turns main off, standby stays running.
// [RQ3] Force-off overrides on-request and bus commands.
// [RQ4] On-request high or open disables main output.
// [RQ5] No input power: both lamps dark.
// [RQ6] Failure: green off, amber steady.
// [RQ7] Warning while operating: green off, amber blinks 1 Hz.
// [RQ8] Power present, main off: green blinks 1 Hz, amber dark.
// [RQ9] Main on without fault: green steady, amber dark.
// [RQ10] Fan failure latches off; restart by on-request cycle, power cycle, bus command.
// [RQ11] Main over-voltage latches main off within 1 ms.
// [RQ12] Standby over-voltage latches standby off within 1 ms.
// [RQ13] Short circuit below 3 V limits current within 2 ms.
// [RQ14] Short circuit held 500 ms latches main off.
// [RQ15] Heat-sink over-temperature shuts down automatically.
// [RQ16] Current within 2 A of protection point raises a warning.
// [RQ17] Alert output low while any critical or warning event is active.
// [RQ18] Presence output permanently at output ground.
// [RQ19] Lamp blink from clock at 50% duty; priority failure, warning, off, on.
// [RQ20] Latches clear on on-request falling edge or reset.
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pso_onoff
   import pso_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic        FORCE_OFF_INPUT,
   input  wire logic        MAIN_ON_REQUEST_N,
   input  wire logic        INPUT_POWER_OK,
   input  wire logic        MAIN_OV_DET,
   input  wire logic        STANDBY_OV_DET,
   input  wire logic        MAIN_SHORT_DET,
   input  wire logic        OVER_TEMP_DET,
   input  wire logic        FAN_FAIL_DET,
   input  wire logic        HIGH_TEMP_WARN,
   input  wire logic        SLOW_FAN_WARN,
   input  wire logic        NEAR_OVERCURRENT_DET,
   output logic             MAIN_ENABLE,
   output logic             STANDBY_ENABLE,
   output logic             CURRENT_LIMIT,
   output logic             GREEN_LAMP,
   output logic             AMBER_LAMP,
   output logic             FAULT_ALERT_OUT_N_O,
   output logic             FAULT_ALERT_OUT_N_OE,
   output logic             PRESENT_N,
   input  wire logic [3:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [3:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);
   import pso_pkg::*;

   localparam int N_IN = 11;
   logic [N_IN-1:0] pin_raw;
   logic [N_IN-1:0] sync1_q;
   logic [N_IN-1:0] sync2_q;
   logic            force_off_level;
   logic            main_on_request_level;
   logic            ac_ok;
   logic            main_ov;
   logic            sb_ov;
   logic            short_det;
   logic            over_temp;
   logic            fan_fail;
   logic            warn_any;
   logic            near_overcurrent;
   logic            req_n_d1_q;
   logic            req_fall;
   logic            main_ov_lat_q;
   logic            sb_ov_lat_q;
   logic            sc_lat_q;
   logic            ot_lat_q;
   logic            fan_lat_q;
   logic            latched_off;
   logic [CNT_W-1:0] sc_cnt_q;
   logic [CNT_W-1:0] blink_cnt_q;
   logic            blink_q;
   logic            bus_on_q;
   logic            restart_q;
   logic            clear_all;
   logic            failure;
   logic            warning;
   logic            main_on_d;
   logic            main_on_q;
   logic            green_q;
   logic            amber_q;
   logic            alert_q;
   logic            aw_held_q;
   logic            w_held_q;
   logic [3:0]      aw_addr_q;
   logic [31:0]     w_data_q;
   logic [3:0]      w_strb_q;
   pso_lamp_type    green_mode;
   pso_lamp_type    amber_mode;

   // Every pin passes two flops; the first stage feeds nothing but the second
   assign pin_raw = {NEAR_OVERCURRENT_DET, SLOW_FAN_WARN, HIGH_TEMP_WARN, FAN_FAIL_DET,
                     OVER_TEMP_DET, MAIN_SHORT_DET, STANDBY_OV_DET, MAIN_OV_DET,
                     INPUT_POWER_OK, MAIN_ON_REQUEST_N, FORCE_OFF_INPUT};
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         sync1_q <= 11'h003;   // Pulled-up control pins start as open
         sync2_q <= 11'h003;
      end
      else
      begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end

   assign force_off_level       = sync2_q[0];
   assign main_on_request_level = sync2_q[1];
   assign ac_ok                 = sync2_q[2];
   assign main_ov               = sync2_q[3];
   assign sb_ov                 = sync2_q[4];
   assign short_det             = sync2_q[5];
   assign over_temp             = sync2_q[6];
   assign fan_fail              = sync2_q[7];
   assign near_overcurrent      = sync2_q[10];
   assign warn_any              = sync2_q[8] | sync2_q[9] | near_overcurrent; // RQ16

   // On-request falling edge, read from the second stage only
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         req_n_d1_q <= 1'b1;
      else
         req_n_d1_q <= main_on_request_level;
   end
   assign req_fall  = req_n_d1_q & ~main_on_request_level;
   // A bus restart or loss of input power also counts as a fresh start
   assign clear_all = req_fall | restart_q | ~ac_ok; // RQ20

   // Protection latches: a new detection wins over a clear in the same cycle
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         main_ov_lat_q <= 1'b0;
         sb_ov_lat_q   <= 1'b0;
         ot_lat_q      <= 1'b0;
         fan_lat_q     <= 1'b0;
      end
      else
      begin
         main_ov_lat_q <= main_ov   | (main_ov_lat_q & ~clear_all); // RQ11
         sb_ov_lat_q   <= sb_ov     | (sb_ov_lat_q & ~clear_all);   // RQ12
         ot_lat_q      <= over_temp | (ot_lat_q & ~clear_all);      // RQ15
         fan_lat_q     <= fan_fail  | (fan_lat_q & ~clear_all);     // RQ10
      end
   end

   // Short-circuit timer: current limit follows the synchronised pin with no timer, latch after a held 500 ms
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         sc_cnt_q <= '0;
         sc_lat_q <= 1'b0;
      end
      else
      begin
         if (!short_det)
            sc_cnt_q <= '0;
         else if (sc_cnt_q < CNT_W'(SC_LATCH_CYC))
            sc_cnt_q <= sc_cnt_q + 1'b1;
         sc_lat_q <= (short_det && sc_cnt_q >= CNT_W'(SC_LATCH_CYC - 1))
                     | (sc_lat_q & ~clear_all); // RQ14
      end
   end
   // Foldback asserts two cycles after the pin, well inside 2 ms
   assign CURRENT_LIMIT = short_det; // RQ13

   assign latched_off = main_ov_lat_q | sb_ov_lat_q | sc_lat_q | ot_lat_q | fan_lat_q;
   assign failure     = latched_off;

   // Main enable: force-off overrides request and bus; open pins read high
   assign main_on_d = ~force_off_level & ~main_on_request_level & bus_on_q // RQ1 RQ3 RQ4
                      & ac_ok & ~latched_off;
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         main_on_q <= 1'b0;
      else
         main_on_q <= main_on_d;
   end
   assign MAIN_ENABLE    = main_on_q;
   // Standby ignores force-off and only stops on its own over-voltage
   assign STANDBY_ENABLE = ~sb_ov_lat_q; // RQ2 RQ12
   assign PRESENT_N      = 1'b0; // RQ18

   // Free-running 1 Hz blink, half period each level
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         blink_cnt_q <= '0;
         blink_q     <= 1'b0;
      end
      else if (blink_cnt_q == CNT_W'(BLINK_HALF_CYC - 1))
      begin
         blink_cnt_q <= '0;
         blink_q     <= ~blink_q; // RQ19
      end
      else
         blink_cnt_q <= blink_cnt_q + 1'b1;
   end

   // Lamp priority: no power, failure, warning, off, on
   assign warning = warn_any & main_on_q;
   always_comb
   begin
      if (!ac_ok)
      begin
         green_mode = LAMP_OFF;   // RQ5
         amber_mode = LAMP_OFF;
      end
      else if (failure)
      begin
         green_mode = LAMP_OFF;   // RQ6
         amber_mode = LAMP_ON;
      end
      else if (warning)
      begin
         green_mode = LAMP_OFF;   // RQ7
         amber_mode = LAMP_BLINK;
      end
      else if (!main_on_q)
      begin
         green_mode = LAMP_BLINK; // RQ8
         amber_mode = LAMP_OFF;
      end
      else
      begin
         green_mode = LAMP_ON;    // RQ9
         amber_mode = LAMP_OFF;
      end
   end

   function automatic logic lamp_level(input pso_lamp_type m, input logic b);
      case (m)
         LAMP_ON:    lamp_level = 1'b1;
         LAMP_BLINK: lamp_level = b;
         default:    lamp_level = 1'b0;
      endcase
   endfunction

   // Lamps and alert are registered so the pins never glitch
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         green_q <= 1'b0;
         amber_q <= 1'b0;
         alert_q <= 1'b0;
      end
      else
      begin
         green_q <= lamp_level(green_mode, blink_q);
         amber_q <= lamp_level(amber_mode, blink_q);
         alert_q <= failure | warn_any; // RQ17
      end
   end
   assign GREEN_LAMP           = green_q;
   assign AMBER_LAMP           = amber_q;
   assign FAULT_ALERT_OUT_N_O  = 1'b0;
   assign FAULT_ALERT_OUT_N_OE = alert_q; // RQ17

   // AXI4-Lite write: address and data taken in either order, then response
   assign S_AXI_AWREADY = ~aw_held_q & ~S_AXI_BVALID;
   assign S_AXI_WREADY  = ~w_held_q & ~S_AXI_BVALID;
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         aw_held_q    <= 1'b0;
         w_held_q     <= 1'b0;
         aw_addr_q    <= '0;
         w_data_q     <= '0;
         w_strb_q     <= '0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= RESP_OKAY;
         bus_on_q     <= CTRL_BUSON_RST;
         restart_q    <= 1'b0;
      end
      else
      begin
         restart_q <= 1'b0;
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_held_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
         end
         if (aw_held_q && w_held_q)
         begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            if (aw_addr_q == CTRL_OFS)
            begin
               S_AXI_BRESP <= RESP_OKAY;
               if (w_strb_q[0])
               begin
                  bus_on_q  <= w_data_q[CTRL_BUSON_BIT];
                  restart_q <= w_data_q[CTRL_RESTART_BIT]; // RQ10
               end
            end
            else
               S_AXI_BRESP <= RESP_SLVERR;
         end
         else if (S_AXI_BVALID && S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
      end
   end

   // AXI4-Lite read: one cycle to data, held until taken
   assign S_AXI_ARREADY = ~S_AXI_RVALID;
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= '0;
         S_AXI_RRESP  <= RESP_OKAY;
      end
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP  <= RESP_OKAY;
         case (S_AXI_ARADDR)
            CTRL_OFS:   S_AXI_RDATA <= {30'h0, bus_on_q, 1'b0};
            STATUS_OFS: S_AXI_RDATA <= {20'h0, warn_any, sc_lat_q, fan_lat_q, ot_lat_q,
                                        sb_ov_lat_q, main_ov_lat_q, short_det, ac_ok,
                                        main_on_request_level, force_off_level,
                                        ~sb_ov_lat_q, main_on_q};
            default:
            begin
               S_AXI_RDATA <= '0;
               S_AXI_RRESP <= RESP_SLVERR;
            end
         endcase
      end
      else if (S_AXI_RREADY)
         S_AXI_RVALID <= 1'b0;
   end

   // Checks
   sequence s_ov_seen;
      main_ov;
   endsequence
   // The enable flop may still carry one old 'on' cycle while the latch sets
   chk_main_ov_latch: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ11
      s_ov_seen ##1 !clear_all |=> !main_on_q [*2])
      else $error("main output not off after over-voltage");
   chk_sb_ov_latch: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ12
      sb_ov |=> !STANDBY_ENABLE)
      else $error("standby not latched off");
   chk_force_off: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ3
      force_off_level |=> !MAIN_ENABLE)
      else $error("main on while force-off high");
   chk_req_off: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ4
      main_on_request_level |=> !MAIN_ENABLE)
      else $error("main on while request high");
   chk_main_on: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ1
      (!force_off_level && !main_on_request_level && bus_on_q && ac_ok && !latched_off)
      |=> MAIN_ENABLE)
      else $error("main not enabled with both inputs low");
   chk_fan_latch: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ10
      (fan_fail && !clear_all) ##1 (!fan_fail && !clear_all) |-> fan_lat_q)
      else $error("fan latch lost without restart");
   chk_no_power_dark: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ5
      !ac_ok |=> !GREEN_LAMP && !AMBER_LAMP)
      else $error("lamp lit without input power");
   chk_fail_amber: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ6
      (ac_ok && failure) |=> AMBER_LAMP && !GREEN_LAMP)
      else $error("failure lamp pattern wrong");
   chk_alert: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ17
      (failure || warn_any) |=> FAULT_ALERT_OUT_N_OE)
      else $error("alert not driven on event");
   chk_on_green: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ9
      (ac_ok && main_on_q && !failure && !warn_any) |=> GREEN_LAMP && !AMBER_LAMP)
      else $error("on lamp pattern wrong");
   chk_present: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ18
      !PRESENT_N)
      else $error("presence not grounded");
   chk_off_blink: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ8
      (ac_ok && !failure && !main_on_q) |=> GREEN_LAMP == $past(blink_q) && !AMBER_LAMP)
      else $error("off lamp pattern wrong");
   chk_warn_blink: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ7
      (ac_ok && !failure && warning) |=> !GREEN_LAMP && AMBER_LAMP == $past(blink_q))
      else $error("warning lamp pattern wrong");
   chk_sc_no_early: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ14
      (!sc_lat_q && sc_cnt_q < CNT_W'(SC_LATCH_CYC - 1)) |=> !sc_lat_q)
      else $error("short latch set before hold time");
endmodule
`default_nettype wire

// ==== testbench/pso_host_model.sv ====
// Backplane and management controller side of the supply control pins.
// Assumes the bench asks for pin levels; open contacts read high via pull-ups.
`timescale 1ns/1ps
`default_nettype none
module pso_host_model
(
   input  wire logic kill_open,
   input  wire logic on_open,
   input  wire logic alert_o,
   input  wire logic alert_oe,
   output logic      force_off,
   output logic      on_req_n,
   output logic      alert_wire
);
   // Grounded contact reads low, open contact floats to the pull-up
   assign force_off = kill_open ? 1'b1 : 1'b0;
   assign on_req_n  = on_open ? 1'b1 : 1'b0;
   // Open-drain alert resolved with the receiver pull-up, never left floating
   assign alert_wire = alert_oe ? alert_o : 1'b1;
endmodule
`default_nettype wire

// ==== testbench/pso_onoff_bench.sv ====
// Self-checking bench for the supply on/off, latch, lamp and alert logic.
// Assumes pso_pkg, the design and the host model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module pso_onoff_bench;
   import pso_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        kill_open = 1'b1;
   logic        on_open = 1'b1;
   logic        pwr_ok = 1'b1;
   logic [4:0]  det = 5'h00;   // Main OV, standby OV, short, over-temp, fan
   logic [2:0]  warn = 3'h0;
   logic [3:0]  awaddr = 4'h0;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        wvalid = 1'b0;
   logic [3:0]  wstrb = 4'hF;
   logic        bready = 1'b0;
   logic [3:0]  araddr = 4'h0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        main_en, sb_en, cur_lim, green, amber, al_o, al_oe, pres_n;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   wire logic   force_off, on_req_n, alert_wire;
   wire logic [6:0] pins_now = {main_en, sb_en, cur_lim, green, amber, alert_wire, pres_n};
   int          fail_count = 0;
   int          n_checks = 0;
   int          seed = 32'hc151ef17;
   logic [13:0] pin_q[$];
   logic [33:0] bus_q[$];
   event        snap_ev;
   localparam logic [6:0] ON_V = 7'b1101010;
   localparam logic [6:0] OFF_V = 7'b0100010;

   always #5 clk_sys = ~clk_sys;

   pso_onoff dut_u (
      .CLK_SYS(clk_sys), .RST(rst), .FORCE_OFF_INPUT(force_off),
      .MAIN_ON_REQUEST_N(on_req_n), .INPUT_POWER_OK(pwr_ok),
      .MAIN_OV_DET(det[4]), .STANDBY_OV_DET(det[3]), .MAIN_SHORT_DET(det[2]),
      .OVER_TEMP_DET(det[1]), .FAN_FAIL_DET(det[0]), .HIGH_TEMP_WARN(warn[0]),
      .SLOW_FAN_WARN(warn[1]), .NEAR_OVERCURRENT_DET(warn[2]), .MAIN_ENABLE(main_en),
      .STANDBY_ENABLE(sb_en), .CURRENT_LIMIT(cur_lim), .GREEN_LAMP(green),
      .AMBER_LAMP(amber), .FAULT_ALERT_OUT_N_O(al_o), .FAULT_ALERT_OUT_N_OE(al_oe),
      .PRESENT_N(pres_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

   pso_host_model host_u (
      .kill_open(kill_open), .on_open(on_open), .alert_o(al_o), .alert_oe(al_oe),
      .force_off(force_off), .on_req_n(on_req_n), .alert_wire(alert_wire));

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (fail_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Let n edges pass, then stop mid-cycle where outputs have settled
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   // Note the expected pin picture under a mask and ask the watcher to look
   task automatic pins(input logic [6:0] mask, input logic [6:0] val);
      pin_q.push_back({mask, val});
      ->snap_ev;
   endtask

   // One bus transfer; every channel held until its own handshake edge
   task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [33:0] e);
      int   i;
      logic aw, ar, wh, rh;
      bus_q.push_back(e);
      @(posedge clk_sys);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= wr;
      wvalid <= wr;
      bready <= wr;
      arvalid <= !wr;
      rready <= !wr;
      for (i = 0; i < 60; i++)
      begin
         @(negedge clk_sys);
         aw = awvalid & awready;
         ar = arvalid & arready;
         wh = wvalid & wready;
         rh = (bvalid & bready) | (rvalid & rready);
         @(posedge clk_sys);
         if (aw)
            awvalid <= 1'b0;
         if (ar)
            arvalid <= 1'b0;
         if (wh)
            wvalid <= 1'b0;
         if (rh)
         begin
            bready <= 1'b0;
            rready <= 1'b0;
            break;
         end
      end
      if (i == 60)
      begin
         fail_count++;
         end_of_test();
      end
   endtask

   // Pin watcher; masked bits cover blink phases and pins a step does not check
   always @(snap_ev)
   begin
      logic [13:0] e;
      e = pin_q.pop_front();
      check(34'(pins_now & e[13:7]), 34'(e[6:0] & e[13:7]));
   end

   // Bus watcher takes the oldest note at each response handshake
   always @(posedge clk_sys)
   begin
      if (bvalid === 1'b1 && bready)
         check({bresp, 32'h0}, bus_q.pop_front());
      if (rvalid === 1'b1 && rready)
         check({rresp, rdata}, bus_q.pop_front());
   end

   // A hang counts as a mismatch and ends the run
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      end_of_test();
   end

   initial
   begin
      int         k;
      logic [1:0] c;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      settle(1);
      pins(7'h77, OFF_V);
      axi(1'b0, CTRL_OFS, 32'h0, {RESP_OKAY, 32'h2});
      axi(1'b0, STATUS_OFS, 32'h0, {RESP_OKAY, 32'h1E});
      axi(1'b0, 4'h8, 32'h0, {RESP_SLVERR, 32'h0});
      axi(1'b1, 4'hC, 32'hFFFFFFFF, {RESP_SLVERR, 32'h0});
      // Every pin combination, then random ones
      for (k = 0; k < 10; k++)
      begin
         c = (k < 4) ? 2'(k) : 2'($random(seed));
         @(posedge clk_sys);
         kill_open <= c[1];
         on_open <= c[0];
         settle(8);
         pins((c == 2'h0) ? 7'h7F : 7'h77, (c == 2'h0) ? ON_V : OFF_V);
      end
      @(posedge clk_sys);
      kill_open <= 1'b0;
      on_open <= 1'b0;
      // Bus on-request off and back on
      axi(1'b1, CTRL_OFS, 32'h0, {RESP_OKAY, 32'h0});
      settle(8);
      pins(7'h77, OFF_V);
      axi(1'b1, CTRL_OFS, 32'h2, {RESP_OKAY, 32'h0});
      settle(8);
      pins(7'h7F, ON_V);
      // Lane 0 disabled: the write is answered but leaves the bus request on
      @(posedge clk_sys);
      wstrb <= 4'h0;
      axi(1'b1, CTRL_OFS, 32'h0, {RESP_OKAY, 32'h0});
      wstrb <= 4'hF;
      settle(8);
      pins(7'h7F, ON_V);
      // Each warning alone: supply keeps running, alert pulled low
      for (k = 0; k < 3; k++)
      begin
         @(posedge clk_sys);
         warn <= 3'(1 << k);
         settle(8);
         pins(7'h7B, 7'b1100000);
         @(posedge clk_sys);
         warn <= 3'h0;
         settle(8);
         pins(7'h7F, ON_V);
      end
      // Critical faults: main OV and fan cleared by an on-request cycle, standby OV by bus restart, over-temp by power loss
      for (k = 0; k < 4; k++)
      begin
         @(posedge clk_sys);
         det <= 5'h10 >> (k + int'(k > 1));
         settle(8);
         pins(7'h7F, {1'b0, k != 1, 5'b00100});
         @(posedge clk_sys);
         det <= 5'h00;
         settle(8);
         pins(7'h7D, {1'b0, k != 1, 5'b00100});
         if (k == 1)
            axi(1'b1, CTRL_OFS, 32'h3, {RESP_OKAY, 32'h0});
         else
         begin
            @(posedge clk_sys);
            pwr_ok <= (k != 2);
            on_open <= (k != 2);
            settle(8);
            pins((k == 2) ? 7'h0C : 7'h40, 7'h00);
            @(posedge clk_sys);
            pwr_ok <= 1'b1;
            on_open <= 1'b0;
         end
         settle(8);
         pins(7'h7F, ON_V);
      end
      // Short circuit: limit quickly, no early latch-off
      @(posedge clk_sys);
      det <= 5'h04;
      settle(8);
      pins(7'h71, 7'b1110000);
      @(posedge clk_sys);
      det <= 5'h00;
      settle(8);
      pins(7'h7F, ON_V);
      settle(4);
      end_of_test();
   end
endmodule
`default_nettype wire
